/* File: hdl/i2c_host_receive_arbitration.sv */
// i2c host receive path, start generation, acknowledge sequence and bus arbitration
// ==========================================================
// Operation
// R1: receive request ignored unless port idle
// R2: each divider rollover toggles scl, shifts sda
// R3: eighth fall: load buffer, flags, hold scl
// R4: buffer read clears buffer full flag
// R5: byte arrives while full: set overflow
// R6: buffer write during shifting: collision, ignored
// R7: software sequences start, address, bytes, nack/stop
// R8: address ack captured, interrupt after ninth clock
// R9: start/stop seen cleared by reset, disable
// R10: software takes bus only when free
// R11: always monitor bus, stop sets interrupt
// R12: released high sampled low: collision, idle
// R13: arbitration checked in transmit data bit and ack high phases
// R14: transmit collision clears full, releases lines
// R15: sequence collision aborts, clears its enable
// R16: write after collision restarts at bit one
// R17: line low at start: abort, collision
// R18: start count; scl low while sda high collides
// R19: sda low during count: early assert, no collision
// R20: sda high: drive low, recount, then scl low
// R21: ack sequence holds scl, drives ack value
// R22: software keeps reload value at three or more
// R23: lines only pulled low, sample while scl high
`timescale 1ns/1ps
module i2c_host_receive_arbitration
    import i2c_rx_arb_pkg::*;
#(
    parameter int DATA_WIDTH = DATA_W
)(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // configuration
    input wire logic port_enable_in,
    input wire logic [7:0] reload_value_in,
    input wire logic ack_data_value_in,
    // software strobes and data
    input wire sw_ctrl_t ctrl_in,
    input wire logic [DATA_WIDTH-1:0] buf_wdata_in,
    // i2c pins
    input wire logic sda_pin_in,
    input wire logic scl_pin_in,
    output logic sda_o_out,
    output logic sda_oe_out,
    output logic scl_o_out,
    output logic scl_oe_out,
    // status to software
    output logic [DATA_WIDTH-1:0] port_data_buffer_out,
    output sw_status_t status_out
);

    typedef enum {
        ST_IDLE, ST_START_A, ST_START_B, ST_TX_LOW, ST_TX_HIGH, ST_RX_LOW, ST_RX_HIGH,
        ST_ACK_LOW, ST_ACK_HIGH, ST_ACK_END
    } state_t;

    state_t state_q;
    logic [7:0] baud_divider_counter_q;
    logic [DATA_WIDTH-1:0] port_shift_register_q;
    logic [DATA_WIDTH-1:0] port_data_buffer_q;
    logic [3:0] bit_cnt_q;
    logic sda_drive_low_q;
    logic scl_drive_low_q;
    logic buffer_full_flag_q;
    logic receive_overflow_flag_q;
    logic write_collision_flag_q;
    logic port_interrupt_flag_q;
    logic bus_collision_flag_q;
    logic ack_status_bit_q;
    logic start_seen_q;
    logic stop_seen_q;
    logic sda_s;
    logic scl_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic rollover;
    logic collide;
    logic start_bad;
    logic byte_done;
    logic ninth_done;
    logic tx_fire;
    logic [7:0] reload_safe;

    i2c_line_sync u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .sda_pin_in(sda_pin_in),
        .scl_pin_in(scl_pin_in),
        .sda_out(sda_s),
        .scl_out(scl_s),
        .scl_rise_out(scl_rise),
        .scl_fall_out(scl_fall),
        .start_det_out(start_det),
        .stop_det_out(stop_det)
    );

    // ==========================================================
    // decode
    // guard against reload values too small to give a usable clock
    assign reload_safe = (reload_value_in < RELOAD_MIN) ? RELOAD_MIN : reload_value_in;
    assign rollover = (baud_divider_counter_q == 8'h00_00);
    // released sda seen low while scl high, in transmit data bit and ack high phases (R12, R13)
    assign collide = !sda_drive_low_q && !sda_s && scl_s &&
        ((state_q == ST_TX_HIGH && port_shift_register_q[DATA_WIDTH-1] && bit_cnt_q < 4'd8) ||
         (state_q == ST_ACK_HIGH && ack_data_value_in) ||
         (state_q == ST_START_A && !scl_s));
    assign start_bad = ctrl_in.start_req && state_q == ST_IDLE && (!sda_s || !scl_s); // R17
    assign byte_done = (state_q == ST_RX_LOW) && rollover && (bit_cnt_q == 4'd8); // R3
    assign ninth_done = (state_q == ST_TX_LOW) && rollover && (bit_cnt_q == 4'd9); // R8
    // buffer write accepted only while nothing is shifting (R6, R14, R16)
    assign tx_fire = ctrl_in.buf_write && state_q == ST_IDLE;

    // ==========================================================
    // sequencer
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !port_enable_in) begin
            state_q <= ST_IDLE;
            baud_divider_counter_q <= 8'h00_00;
            bit_cnt_q <= 4'h0;
            sda_drive_low_q <= 1'b0;
            scl_drive_low_q <= 1'b0;
            port_shift_register_q <= '0;
        end else if (start_bad) begin
            state_q <= ST_IDLE; // R17
            sda_drive_low_q <= 1'b0;
            scl_drive_low_q <= 1'b0;
        end else if (collide || (state_q == ST_START_A && !scl_s && sda_s && !sda_drive_low_q)) begin
            // abort, release both lines (R12 R14 R15 R18)
            state_q <= ST_IDLE;
            baud_divider_counter_q <= 8'h00_00;
            sda_drive_low_q <= 1'b0;
            scl_drive_low_q <= 1'b0;
        end else begin
            if (!rollover) begin
                baud_divider_counter_q <= baud_divider_counter_q - 8'h00_01;
            end
            case (state_q)
                ST_IDLE: begin
                    if (ctrl_in.start_req) begin
                        state_q <= ST_START_A; // R18
                        baud_divider_counter_q <= reload_safe;
                    end else if (tx_fire) begin
                        state_q <= ST_TX_LOW; // R16
                        port_shift_register_q <= buf_wdata_in;
                        bit_cnt_q <= 4'h0;
                        baud_divider_counter_q <= reload_safe;
                    end else if (ctrl_in.rx_req) begin
                        state_q <= ST_RX_LOW; // R1
                        bit_cnt_q <= 4'h0;
                        sda_drive_low_q <= 1'b0;
                        scl_drive_low_q <= 1'b1;
                        baud_divider_counter_q <= reload_safe;
                    end else if (ctrl_in.ack_req) begin
                        state_q <= ST_ACK_LOW; // R21
                        scl_drive_low_q <= 1'b1;
                        sda_drive_low_q <= ~ack_data_value_in;
                        baud_divider_counter_q <= reload_safe;
                    end
                end
                ST_START_A: begin
                    if (!sda_s) begin
                        sda_drive_low_q <= 1'b1; // R19
                        state_q <= ST_START_B;
                        baud_divider_counter_q <= reload_safe;
                    end else if (rollover) begin
                        sda_drive_low_q <= 1'b1; // R20
                        state_q <= ST_START_B;
                        baud_divider_counter_q <= reload_safe;
                    end
                end
                ST_START_B: begin
                    if (rollover) begin
                        scl_drive_low_q <= 1'b1; // R20
                        state_q <= ST_IDLE;
                    end
                end
                ST_TX_LOW: begin
                    scl_drive_low_q <= 1'b1;
                    if (bit_cnt_q < 4'd8) begin
                        sda_drive_low_q <= ~port_shift_register_q[DATA_WIDTH-1];
                    end else begin
                        sda_drive_low_q <= 1'b0;
                    end
                    if (ninth_done) begin
                        state_q <= ST_IDLE; // R8
                    end else if (rollover) begin
                        scl_drive_low_q <= 1'b0;
                        state_q <= ST_TX_HIGH;
                        baud_divider_counter_q <= reload_safe;
                    end
                end
                ST_TX_HIGH: begin
                    // clock stretching: count only once scl is seen high (R23)
                    if (!scl_s) begin
                        baud_divider_counter_q <= reload_safe;
                    end else if (rollover) begin
                        scl_drive_low_q <= 1'b1;
                        if (bit_cnt_q < 4'd8) begin
                            port_shift_register_q <= {port_shift_register_q[DATA_WIDTH-2:0], 1'b0};
                        end
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        state_q <= ST_TX_LOW;
                        baud_divider_counter_q <= reload_safe;
                    end
                end
                ST_RX_LOW: begin
                    if (byte_done) begin
                        state_q <= ST_IDLE; // R3
                    end else if (rollover) begin
                        scl_drive_low_q <= 1'b0; // R2
                        state_q <= ST_RX_HIGH;
                        baud_divider_counter_q <= reload_safe;
                    end
                end
                ST_RX_HIGH: begin
                    if (!scl_s) begin
                        baud_divider_counter_q <= reload_safe;
                    end else if (rollover) begin
                        // sample while scl high, then pull low (R2, R23)
                        port_shift_register_q <= {port_shift_register_q[DATA_WIDTH-2:0], sda_s};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        scl_drive_low_q <= 1'b1;
                        state_q <= ST_RX_LOW;
                        baud_divider_counter_q <= reload_safe;
                    end
                end
                ST_ACK_LOW: begin
                    if (rollover) begin
                        scl_drive_low_q <= 1'b0; // R21
                        state_q <= ST_ACK_HIGH;
                        baud_divider_counter_q <= reload_safe;
                    end
                end
                ST_ACK_HIGH: begin
                    if (!scl_s) begin
                        baud_divider_counter_q <= reload_safe;
                    end else if (rollover) begin
                        scl_drive_low_q <= 1'b1; // R21
                        state_q <= ST_ACK_END;
                    end
                end
                ST_ACK_END: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // data buffer and buffer flags
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            port_data_buffer_q <= BYTE_RST;
            buffer_full_flag_q <= 1'b0;
            receive_overflow_flag_q <= 1'b0;
        end else begin
            if (byte_done) begin
                port_data_buffer_q <= port_shift_register_q; // R3
                buffer_full_flag_q <= 1'b1; // R3
                if (buffer_full_flag_q) begin
                    receive_overflow_flag_q <= 1'b1; // R5
                end
            end else if (collide && state_q == ST_TX_HIGH) begin
                buffer_full_flag_q <= 1'b0; // R14
            end else if (tx_fire && !start_bad && !ctrl_in.start_req) begin
                port_data_buffer_q <= buf_wdata_in;
                buffer_full_flag_q <= 1'b1;
            end else if (state_q == ST_TX_HIGH && rollover && scl_s && bit_cnt_q == 4'd7) begin
                buffer_full_flag_q <= 1'b0;
            end else if (ctrl_in.buf_read) begin
                buffer_full_flag_q <= 1'b0; // R4
            end
            if (ctrl_in.clr_ovf && !(byte_done && buffer_full_flag_q)) begin
                receive_overflow_flag_q <= 1'b0;
            end
        end
    end

    // ==========================================================
    // event flags: a set in the same cycle as a clear wins
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            write_collision_flag_q <= 1'b0;
            port_interrupt_flag_q <= 1'b0;
            bus_collision_flag_q <= 1'b0;
            ack_status_bit_q <= 1'b0;
        end else begin
            if (ctrl_in.buf_write && state_q != ST_IDLE) begin
                write_collision_flag_q <= 1'b1; // R6
            end else if (ctrl_in.clr_write_collision_flag) begin
                write_collision_flag_q <= 1'b0;
            end
            if (byte_done || ninth_done || stop_det || state_q == ST_ACK_END ||
                (state_q == ST_START_B && rollover)) begin
                port_interrupt_flag_q <= 1'b1; // R3 R8 R11
            end else if (ctrl_in.clr_irq) begin
                port_interrupt_flag_q <= 1'b0;
            end
            if (start_bad || collide ||
                (state_q == ST_START_A && !scl_s && sda_s && !sda_drive_low_q)) begin
                bus_collision_flag_q <= 1'b1; // R12 R17 R18
            end else if (ctrl_in.clr_bcol) begin
                bus_collision_flag_q <= 1'b0;
            end
            if (state_q == ST_TX_HIGH && bit_cnt_q == 4'd8 && scl_s && rollover) begin
                ack_status_bit_q <= sda_s; // R8
            end
        end
    end

    // ==========================================================
    // bus free tracking
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !port_enable_in) begin
            start_seen_q <= 1'b0; // R9
            stop_seen_q <= 1'b0;
        end else if (start_det) begin
            start_seen_q <= 1'b1; // R11
            stop_seen_q <= 1'b0;
        end else if (stop_det) begin
            stop_seen_q <= 1'b1;
            start_seen_q <= 1'b0;
        end
    end

    // ==========================================================
    // outputs: lines are only ever pulled low (R23)
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sda_oe_out <= 1'b0;
            scl_oe_out <= 1'b0;
            status_out <= '0;
            port_data_buffer_out <= BYTE_RST;
        end else begin
            sda_oe_out <= sda_drive_low_q;
            scl_oe_out <= scl_drive_low_q;
            port_data_buffer_out <= port_data_buffer_q;
            status_out.start_seq_enable <= state_q == ST_START_A || state_q == ST_START_B; // R15
            status_out.receive_enable_bit <= state_q == ST_RX_LOW || state_q == ST_RX_HIGH;
            status_out.ack_sequence_enable <= state_q == ST_ACK_LOW || state_q == ST_ACK_HIGH ||
                state_q == ST_ACK_END;
            status_out.buffer_full_flag <= buffer_full_flag_q;
            status_out.receive_overflow_flag <= receive_overflow_flag_q;
            status_out.write_collision_flag <= write_collision_flag_q;
            status_out.port_interrupt_flag <= port_interrupt_flag_q;
            status_out.bus_collision_flag <= bus_collision_flag_q;
            status_out.ack_status_bit <= ack_status_bit_q;
            status_out.start_seen <= start_seen_q;
            status_out.stop_seen <= stop_seen_q;
            status_out.busy <= state_q != ST_IDLE;
        end
    end

    assign sda_o_out = 1'b0;
    assign scl_o_out = 1'b0;

endmodule

/* File: common/i2c_rx_arb_pkg.sv */
// package: constants and carrier types for the i2c host receive and arbitration block
package i2c_rx_arb_pkg;

    // ==========================================================
    // widths and reset values
    localparam int DATA_W = 8;
    localparam int BITS_PER_BYTE = 8;
    localparam logic [7:0] RELOAD_RST = 8'h00_09;
    localparam logic [7:0] BYTE_RST = 8'h00_00;
    localparam logic [7:0] RELOAD_MIN = 8'h00_03;

    // ==========================================================
    // software control strobes (one-cycle pulses)
    typedef struct packed {
        logic start_req;
        logic rx_req;
        logic ack_req;
        logic buf_write;
        logic buf_read;
        logic clr_write_collision_flag;
        logic clr_ovf;
        logic clr_irq;
        logic clr_bcol;
    } sw_ctrl_t;

    // status seen by software
    typedef struct packed {
        logic start_seq_enable;
        logic receive_enable_bit;
        logic ack_sequence_enable;
        logic buffer_full_flag;
        logic receive_overflow_flag;
        logic write_collision_flag;
        logic port_interrupt_flag;
        logic bus_collision_flag;
        logic ack_status_bit;
        logic start_seen;
        logic stop_seen;
        logic busy;
    } sw_status_t;

endpackage

/* File: hdl/i2c_line_sync.sv */
// two-flop synchroniser and bus condition detector for the i2c lines
`timescale 1ns/1ps
module i2c_line_sync
    import i2c_rx_arb_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // raw pins
    input wire logic sda_pin_in,
    input wire logic scl_pin_in,
    // synchronised levels and events
    output logic sda_out,
    output logic scl_out,
    output logic scl_rise_out,
    output logic scl_fall_out,
    output logic start_det_out,
    output logic stop_det_out
);

    logic [1:0] sda_meta_q;
    logic [1:0] scl_meta_q;
    logic sda_prev_q;
    logic scl_prev_q;

    // ==========================================================
    // synchroniser: the first stage feeds only the second
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sda_meta_q <= 2'b11;
            scl_meta_q <= 2'b11;
            sda_prev_q <= 1'b1;
            scl_prev_q <= 1'b1;
        end else begin
            sda_meta_q <= {sda_meta_q[0], sda_pin_in};
            scl_meta_q <= {scl_meta_q[0], scl_pin_in};
            sda_prev_q <= sda_meta_q[1];
            scl_prev_q <= scl_meta_q[1];
        end
    end

    assign sda_out = sda_meta_q[1];
    assign scl_out = scl_meta_q[1];
    assign scl_rise_out = scl_meta_q[1] & ~scl_prev_q;
    assign scl_fall_out = ~scl_meta_q[1] & scl_prev_q;
    assign start_det_out = scl_meta_q[1] & scl_prev_q & sda_prev_q & ~sda_meta_q[1];
    assign stop_det_out = scl_meta_q[1] & scl_prev_q & ~sda_prev_q & sda_meta_q[1];

endmodule

/* File: dv/i2c_rx_arb_checker.sv */
// port checks for the i2c host receive block
`timescale 1ns/1ps
module i2c_rx_arb_checker
    import i2c_rx_arb_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // configuration and software side
    input wire logic port_enable_in,
    input wire logic ack_data_value_in,
    input wire sw_ctrl_t ctrl_in,
    input wire sw_status_t status_out,
    // i2c pins
    input wire logic scl_pin_in,
    input wire logic sda_o_out,
    input wire logic sda_oe_out,
    input wire logic scl_o_out,
    input wire logic scl_oe_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // ==========
    // assertions
    a_open_drain_only: assert property (!sda_o_out && !scl_o_out)
        else $error("high drive");
    a_rx_done_flags: assert property (
        $fell(status_out.receive_enable_bit) && port_enable_in && !status_out.bus_collision_flag
        |-> status_out.buffer_full_flag && status_out.port_interrupt_flag)
        else $error("byte end flags");
    a_ovf_with_byte: assert property (
        $rose(status_out.receive_overflow_flag) |-> $fell(status_out.receive_enable_bit))
        else $error("stray overflow");
    a_read_clears_full: assert property (
        ctrl_in.buf_read && !status_out.busy && !ctrl_in.rx_req |-> ##[1:2] !status_out.buffer_full_flag)
        else $error("full after read");
    a_busy_write_flag: assert property (
        ctrl_in.buf_write && status_out.busy && status_out.receive_enable_bit
        |-> ##[1:3] status_out.write_collision_flag)
        else $error("write collision missed");
    a_disable_clears_seen: assert property (
        !port_enable_in [*3] |-> !status_out.start_seen && !status_out.stop_seen)
        else $error("seen flags kept");
    a_start_sda_first: assert property (
        status_out.start_seq_enable && !sda_oe_out |-> !scl_oe_out)
        else $error("start order");
    a_ack_drives_value: assert property (
        status_out.ack_sequence_enable && !status_out.bus_collision_flag |-> sda_oe_out == !ack_data_value_in)
        else $error("ack level");
    a_coll_release: assert property (
        $rose(status_out.bus_collision_flag) |-> ##[0:2] (!sda_oe_out && !scl_oe_out && !status_out.busy))
        else $error("lines held");
    a_start_line_low: assert property (
        ctrl_in.start_req && !status_out.busy && !scl_oe_out && !$past(scl_pin_in, 3) && !scl_pin_in
        |-> ##[1:8] status_out.bus_collision_flag)
        else $error("start collision missed");
    a_stop_irq: assert property (
        $rose(status_out.stop_seen) |-> ##[0:2] status_out.port_interrupt_flag)
        else $error("stop irq missing");
endmodule
bind i2c_host_receive_arbitration i2c_rx_arb_checker i2c_rx_arb_checker_inst (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .port_enable_in(port_enable_in),
    .ack_data_value_in(ack_data_value_in), .ctrl_in(ctrl_in), .status_out(status_out),
    .scl_pin_in(scl_pin_in), .sda_o_out(sda_o_out), .sda_oe_out(sda_oe_out),
    .scl_o_out(scl_o_out), .scl_oe_out(scl_oe_out)
);

/* File: dv/i2c_client_model.sv */
// i2c client: plays nine bits, can hold either line low
`timescale 1ns/1ps
module i2c_client_model (
    // bus clock as seen on the wire
    input wire logic scl_in,
    // pattern and line holds from the bench
    input wire logic load_in,
    input wire logic [8:0] pattern_in,
    input wire logic hold_sda_in,
    input wire logic hold_scl_in,
    // open-drain pull-downs
    output logic sda_low_out,
    output logic scl_low_out
);
    logic [8:0] pat_q = 9'h1FF;
    logic [3:0] left_q = 4'h0;
    // next bit after each clock fall
    always @(posedge load_in or negedge scl_in) begin
        if (load_in) begin
            pat_q <= pattern_in;
            left_q <= 4'h9;
        end else if (left_q != 4'h0) begin
            pat_q <= {pat_q[7:0], 1'b1};
            left_q <= left_q - 4'h1;
        end
    end
    // pull-down only
    assign sda_low_out = hold_sda_in || (left_q != 4'h0 && !pat_q[8]);
    assign scl_low_out = hold_scl_in;
endmodule

/* File: dv/tb_i2c_host_receive_arbitration.sv */
// bench for the i2c host receive block
`timescale 1ns/1ps
module tb_i2c_host_receive_arbitration;
    import i2c_rx_arb_pkg::*;
    localparam int IRQ_BIT = 5;
    localparam int BCOL_BIT = 4;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic port_enable_in = 1'b1;
    logic [7:0] reload_value_in = RELOAD_MIN;
    logic ack_data_value_in = 1'b0;
    sw_ctrl_t ctrl_in = '0;
    logic [7:0] buf_wdata_in = 8'h00;
    logic load = 1'b0;
    logic hold_sda = 1'b0;
    logic hold_scl = 1'b0;
    logic [8:0] pat = 9'h1FF;
    logic sda_o, sda_oe, scl_o, scl_oe, c_sda, c_scl;
    logic [7:0] rdata;
    sw_status_t st;
    int miscompares = 0;
    int tests_run = 0;
    // wired-and with pull-ups
    wire sda = !((sda_oe && !sda_o) || c_sda);
    wire scl = !((scl_oe && !scl_o) || c_scl);
    always #25 ref_clk_in = ~ref_clk_in;
    i2c_host_receive_arbitration i2c_host_receive_arbitration_inst (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .port_enable_in(port_enable_in),
        .reload_value_in(reload_value_in), .ack_data_value_in(ack_data_value_in), .ctrl_in(ctrl_in),
        .buf_wdata_in(buf_wdata_in), .sda_pin_in(sda), .scl_pin_in(scl), .sda_o_out(sda_o),
        .sda_oe_out(sda_oe), .scl_o_out(scl_o), .scl_oe_out(scl_oe), .port_data_buffer_out(rdata),
        .status_out(st)
    );
    i2c_client_model i2c_client_model_inst (
        .scl_in(scl), .load_in(load), .pattern_in(pat), .hold_sda_in(hold_sda),
        .hold_scl_in(hold_scl), .sda_low_out(c_sda), .scl_low_out(c_scl)
    );
    // ==========
    // helpers
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
        #5;
    endtask
    task automatic pulse(input sw_ctrl_t c);
        ctrl_in = c;
        tick(1);
        ctrl_in = '0;
        tick(1);
    endtask
    task automatic feed(input logic [8:0] p);
        pat = p;
        load = 1'b1;
        tick(1);
        load = 1'b0;
    endtask
    task automatic wait_bit(input int b);
        int n;
        n = 0;
        while (st[b] !== 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
        if (n >= 3000) begin
            miscompares++;
            close_out();
        end
    endtask
    task automatic wait_irq();
        wait_bit(IRQ_BIT);
        pulse('{clr_irq: 1'b1, default: 1'b0});
    endtask
    // ==========
    // scenarios
    task automatic s_start_abort();
        hold_scl = 1'b1;
        tick(4);
        pulse('{start_req: 1'b1, default: 1'b0});
        wait_bit(BCOL_BIT);
        tick(2);
        check({st.start_seq_enable, st.busy, sda_oe, scl_oe}, 0);
        hold_scl = 1'b0;
        pulse('{clr_bcol: 1'b1, default: 1'b0});
    endtask
    task automatic s_start();
        check({st.start_seen, st.busy}, 0);
        pulse('{start_req: 1'b1, default: 1'b0});
        wait_irq();
        check({sda_oe, scl_oe, st.start_seen, st.start_seq_enable}, 4'b1110);
    endtask
    task automatic s_addr();
        feed(9'h1FE);
        buf_wdata_in = 8'hA1;
        pulse('{buf_write: 1'b1, default: 1'b0});
        wait_irq();
        check({st.ack_status_bit, st.bus_collision_flag, scl_oe}, 3'b001);
    endtask
    task automatic s_rx();
        feed({8'hA5, 1'b1});
        pulse('{rx_req: 1'b1, default: 1'b0});
        tick(6);
        buf_wdata_in = 8'h5A;
        pulse('{buf_write: 1'b1, rx_req: 1'b1, default: 1'b0});
        wait_irq();
        check(rdata, 8'hA5);
        check({st.buffer_full_flag, st.write_collision_flag, st.receive_enable_bit, scl_oe}, 4'b1101);
        tick(20);
        check({st.receive_enable_bit, st.busy, scl_oe}, 3'b001);
        pulse('{clr_write_collision_flag: 1'b1, default: 1'b0});
    endtask
    task automatic s_ovf();
        feed({8'h3C, 1'b1});
        pulse('{rx_req: 1'b1, default: 1'b0});
        wait_irq();
        check({st.receive_overflow_flag, st.buffer_full_flag}, 2'b11);
        pulse('{buf_read: 1'b1, default: 1'b0});
        check(st.buffer_full_flag, 0);
        pulse('{clr_ovf: 1'b1, default: 1'b0});
    endtask
    task automatic s_ack();
        ack_data_value_in = 1'b0;
        pulse('{ack_req: 1'b1, default: 1'b0});
        check({st.ack_sequence_enable, sda_oe, scl_oe}, 3'b111);
        wait_irq();
        check({st.ack_sequence_enable, scl_oe, st.busy}, 3'b010);
    endtask
    // nack against a client holding data low
    task automatic s_ack_coll();
        ack_data_value_in = 1'b1;
        feed(9'h000);
        pulse('{ack_req: 1'b1, default: 1'b0});
        wait_bit(BCOL_BIT);
        tick(2);
        check({st.ack_sequence_enable, st.busy, sda_oe, scl_oe}, 0);
        feed(9'h1FF);
        ack_data_value_in = 1'b0;
        tick(4);
        pulse('{clr_bcol: 1'b1, clr_irq: 1'b1, default: 1'b0});
    endtask
    task automatic s_tx_coll();
        check(st.stop_seen, 1);
        pulse('{start_req: 1'b1, default: 1'b0});
        wait_irq();
        feed(9'h17F);
        buf_wdata_in = 8'hFF;
        pulse('{buf_write: 1'b1, default: 1'b0});
        wait_bit(BCOL_BIT);
        tick(2);
        check({st.buffer_full_flag, st.busy, sda_oe, scl_oe}, 0);
        feed(9'h1FF);
        tick(4);
        pulse('{clr_bcol: 1'b1, clr_irq: 1'b1, default: 1'b0});
    endtask
    task automatic s_stop();
        check(st.port_interrupt_flag, 0);
        hold_sda = 1'b1;
        tick(4);
        hold_sda = 1'b0;
        tick(6);
        check({st.stop_seen, st.port_interrupt_flag}, 2'b11);
        port_enable_in = 1'b0;
        tick(4);
        check({st.start_seen, st.stop_seen}, 0);
        port_enable_in = 1'b1;
    endtask
    initial begin
        tick(12);
        rst_in = 1'b0;
        tick(3);
        check({sda_oe, scl_oe, st, rdata}, 0);
        s_start_abort();
        s_start();
        s_addr();
        s_rx();
        s_ovf();
        s_ack();
        s_ack_coll();
        s_tx_coll();
        s_stop();
        close_out();
    end
endmodule
